// ==== design/qcnt_decode.sv ====
// Phase input synchroniser and multiplication-by-4 decoder
`timescale 1ns/10ps
module qcnt_decode (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // Phase bundle
   qcnt_if.dec bus
);
   logic [1:0] sync1;
   logic [1:0] sync2;
   logic [1:0] sync3;
   logic [1:0] prev;
   logic primed;
   logic stable;
   logic is_up;
   logic is_down;

   // -------------------------------------
   // Transition decode
   // -------------------------------------
   // direction table
   function automatic logic dir_up(input logic [1:0] p, input logic [1:0] c);
      return (p == 2'h0 && c == 2'h2) || (p == 2'h2 && c == 2'h3) ||
         (p == 2'h3 && c == 2'h1) || (p == 2'h1 && c == 2'h0);
   endfunction

   assign stable = (sync2 == sync3);
   assign is_up = stable && primed && dir_up(prev, sync3);
   assign is_down = stable && primed && dir_up(sync3, prev);

   // three-stage synchroniser
   // No reset: chain keeps real pin levels across reset
   always_ff @(posedge clk_i) begin
      sync1 <= bus.phase_raw;
      sync2 <= sync1;
      sync3 <= sync2;
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         prev <= 2'h0;
         primed <= 1'b0;
         bus.step_up <= 1'b0;
         bus.step_down <= 1'b0;
      end else begin
         bus.step_up <= 1'b0;
         bus.step_down <= 1'b0;
         if (bus.sample_tick && stable) begin
            prev <= sync3;
            primed <= 1'b1;
            bus.step_up <= is_up;
            bus.step_down <= is_down;
         end
      end
   end
endmodule

// ==== design/qcnt_if.sv ====
// Phase sampling bundle between top and decoder
`timescale 1ns/10ps
interface qcnt_if;
   logic [1:0] phase_raw;
   logic sample_tick;
   logic step_up;
   logic step_down;
   modport top (output phase_raw, output sample_tick,
      input step_up, input step_down);
   modport dec (input phase_raw, input sample_tick,
      output step_up, output step_down);
endinterface

// ==== design/qcnt_pkg.sv ====
// Constants for the quadrature up/down counter block
package qcnt_pkg;
   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [31:0] OFS_RUN = 32'hFFFF_F1E0;
   localparam logic [31:0] OFS_STATUS = 32'hFFFF_F1E4;
   localparam logic [31:0] OFS_COUNT = 32'hFFFF_F1E8;
   localparam logic [31:0] OFS_MASK = 32'hFFFF_F1EC;
   localparam logic [31:0] OFS_CAPTURE = 32'hFFFF_F1F0;
   // ----------------------------------------
   // Control register fields
   // ----------------------------------------
   localparam int RUN_BIT = 0;
   localparam int IDLE_RUN_BIT = 3;
   localparam int UDMODE_BIT = 4;
   localparam int SAMPLE_SEL_BIT = 5;
   localparam int CTRL_W = 8;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] CTRL_WMASK = 8'h39;
   // ----------------------------------------
   // Status fields
   // ----------------------------------------
   localparam int OVF_BIT = 2;
   localparam int UDF_BIT = 3;
   localparam int CNT_BIT = 4;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] STATUS_MASK = 8'h1C;
   // ----------------------------------------
   // Counter values
   // ----------------------------------------
   localparam logic [15:0] CNT_ZERO = 16'h0000;
   localparam logic [15:0] CNT_MAX = 16'hFFFF;
   localparam logic [15:0] CNT_MID = 16'h7FFF;
   localparam logic [15:0] CNT_ONE = 16'h0001;
   // Low-speed sample tick divider (terminal count: one tick per SLOW_DIV+1 clock cycles)
   localparam logic [9:0] SLOW_DIV = 10'h270;
   localparam logic [1:0] FAST_DIV = 2'h3;
endpackage

// ==== design/qcnt_top.sv ====
// Quadrature up/down counter with event status and interrupt
//
// The implementer's own choice: strobed register access.
`timescale 1ns/10ps
module qcnt_top (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // Register port
   input wire logic [31:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [15:0] rdata_o,
   // Phase pins and power state
   input wire logic phase_a_input_i,
   input wire logic phase_b_input_i,
   input wire logic sleep_i,
   // Interrupt, wake and count
   output logic updown_count_interrupt_o,
   output logic wake_o,
   output logic [15:0] count_o
);
   logic [7:0] ctrl;
   logic [7:0] updown_counter_event_status;
   logic [7:0] mask;
   logic [15:0] count;
   logic [15:0] capture;
   logic [15:0] next_count;
   logic [15:0] next_rdata;
   logic [9:0] div;
   logic [9:0] div_limit;
   logic mode_q;
   logic running;
   logic step;
   logic ovf;
   logic udf;
   logic wr_run;
   logic wr_cnt;
   logic wr_mask;
   logic wr_cap;
   logic rd_status;
   logic [7:0] events;
   logic [7:0] next_status;
   qcnt_if link ();

   qcnt_decode u_dec (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .bus(link.dec)
   );

   // -------------------------------------
   // Decode and counter next value
   // -------------------------------------
   assign link.phase_raw = {phase_a_input_i, phase_b_input_i};
   assign wr_run = wr_i && addr_i == qcnt_pkg::OFS_RUN;
   assign wr_cnt = wr_i && addr_i == qcnt_pkg::OFS_COUNT;
   assign wr_mask = wr_i && addr_i == qcnt_pkg::OFS_MASK;
   assign wr_cap = wr_i && addr_i == qcnt_pkg::OFS_CAPTURE;
   assign rd_status = rd_i && addr_i == qcnt_pkg::OFS_STATUS;
   assign running = ctrl[qcnt_pkg::RUN_BIT] &&
      (!sleep_i || ctrl[qcnt_pkg::IDLE_RUN_BIT] ||
       ctrl[qcnt_pkg::UDMODE_BIT]);
   assign div_limit = ctrl[qcnt_pkg::SAMPLE_SEL_BIT] ?
      {8'h00, qcnt_pkg::FAST_DIV} : qcnt_pkg::SLOW_DIV;
   assign link.sample_tick = (div == 10'h000);
   // down steps only in up/down mode
   assign step = running && (link.step_up ||
      (link.step_down && ctrl[qcnt_pkg::UDMODE_BIT]));
   assign ovf = step && link.step_up && count == qcnt_pkg::CNT_MAX;
   assign udf = step && !link.step_up && count == qcnt_pkg::CNT_ZERO;
   assign next_count = link.step_up ? count + qcnt_pkg::CNT_ONE :
      count - qcnt_pkg::CNT_ONE;
   assign events = ({7'h00, ovf} << qcnt_pkg::OVF_BIT) |
      ({7'h00, udf} << qcnt_pkg::UDF_BIT) |
      ({7'h00, step} << qcnt_pkg::CNT_BIT);
   assign next_status = (rd_status ? 8'h00 : updown_counter_event_status)
      | (events & qcnt_pkg::STATUS_MASK);
   assign next_rdata =
      (addr_i == qcnt_pkg::OFS_RUN) ? {8'h00, ctrl} :
      (addr_i == qcnt_pkg::OFS_STATUS) ?
         {8'h00, updown_counter_event_status} :
      (addr_i == qcnt_pkg::OFS_COUNT) ? capture :
      (addr_i == qcnt_pkg::OFS_MASK) ? {8'h00, mask} : 16'h0000;

   // -------------------------------------
   // Sampling divider
   // -------------------------------------
   always_ff @(posedge clk_i) begin
      if (reset_i || div >= div_limit) begin
         div <= 10'h000;
      end else begin
         div <= div + 10'h001;
      end
   end

   // -------------------------------------
   // Control and counter
   // -------------------------------------
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         ctrl <= qcnt_pkg::CTRL_RESET;
         mask <= qcnt_pkg::STATUS_RESET;
         mode_q <= 1'b0;
         count <= qcnt_pkg::CNT_ZERO;
      end else begin
         mode_q <= ctrl[qcnt_pkg::UDMODE_BIT];
         if (wr_run) begin
            ctrl <= wdata_i[7:0] & qcnt_pkg::CTRL_WMASK;
         end
         if (wr_mask) begin
            mask <= wdata_i[7:0] & qcnt_pkg::STATUS_MASK;
         end
         if (ctrl[qcnt_pkg::UDMODE_BIT] && !mode_q) begin
            count <= qcnt_pkg::CNT_MID;
         end else if (!ctrl[qcnt_pkg::RUN_BIT]) begin
            count <= qcnt_pkg::CNT_ZERO;
         end else if (wr_cnt) begin
            count <= wdata_i;
         end else if (step) begin
            count <= next_count;
         end
      end
   end

   // -------------------------------------
   // Status, capture, outputs
   // -------------------------------------
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         updown_counter_event_status <= qcnt_pkg::STATUS_RESET;
         capture <= qcnt_pkg::CNT_ZERO;
         rdata_o <= 16'h0000;
         updown_count_interrupt_o <= 1'b0;
         wake_o <= 1'b0;
         count_o <= qcnt_pkg::CNT_ZERO;
      end else begin
         updown_counter_event_status <= next_status;
         if (wr_cap) begin
            capture <= count;
         end
         if (rd_i) begin
            rdata_o <= next_rdata;
         end else begin
            rdata_o <= 16'h0000;
         end
         updown_count_interrupt_o <= |(next_status & mask);
         wake_o <= sleep_i && |(next_status & mask);
         count_o <= count;
      end
   end

   // -------------------------------------
   // Assertions
   // -------------------------------------
   property p_step_flag;
      @(posedge clk_i) disable iff (reset_i)
      step |=> updown_counter_event_status[qcnt_pkg::CNT_BIT];
   endproperty
   a_step_flag: assert property (p_step_flag)
      else $error("count step did not set flag");

   property p_irq;
      @(posedge clk_i) disable iff (reset_i)
      (step && mask[qcnt_pkg::CNT_BIT] && !wr_mask)
         |=> updown_count_interrupt_o;
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt missing after step");

   property p_ovf;
      @(posedge clk_i) disable iff (reset_i)
      (ovf && !wr_cnt && !wr_run && mode_q)
         |=> count == qcnt_pkg::CNT_ZERO &&
         updown_counter_event_status[qcnt_pkg::OVF_BIT];
   endproperty
   a_ovf: assert property (p_ovf)
      else $error("overflow wrap wrong");

   property p_udf;
      @(posedge clk_i) disable iff (reset_i)
      (udf && !wr_cnt && !wr_run && mode_q)
         |=> count == qcnt_pkg::CNT_MAX &&
         updown_counter_event_status[qcnt_pkg::UDF_BIT];
   endproperty
   a_udf: assert property (p_udf)
      else $error("underflow wrap wrong");

   property p_clear;
      @(posedge clk_i) disable iff (reset_i)
      (rd_status && !step) |=> updown_counter_event_status == 8'h00;
   endproperty
   a_clear: assert property (p_clear)
      else $error("status not cleared by read");

   property p_preload;
      @(posedge clk_i) disable iff (reset_i)
      $rose(ctrl[qcnt_pkg::UDMODE_BIT]) |=> count == qcnt_pkg::CNT_MID;
   endproperty
   a_preload: assert property (p_preload)
      else $error("midpoint preload missing");

   property p_reserved;
      @(posedge clk_i) disable iff (reset_i)
      updown_counter_event_status[7:5] == 3'h0;
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved status bits set");

   property p_wake;
      @(posedge clk_i) disable iff (reset_i)
      (sleep_i && step && mask[qcnt_pkg::CNT_BIT] && !wr_mask)
         |=> wake_o;
   endproperty
   a_wake: assert property (p_wake)
      else $error("no wake on sleep count");

   property p_nodown;
      @(posedge clk_i) disable iff (reset_i)
      (!ctrl[qcnt_pkg::UDMODE_BIT] && ctrl[qcnt_pkg::RUN_BIT] &&
         link.step_down && !wr_cnt && !wr_run) |=> $stable(count);
   endproperty
   a_nodown: assert property (p_nodown)
      else $error("down count in timer mode");

   c_ovf: cover property (@(posedge clk_i) ovf);
   c_udf: cover property (@(posedge clk_i) udf);
   c_wake: cover property (@(posedge clk_i) wake_o);
endmodule

// ==== verification/quad_source.sv ====
// Two-phase encoder model driving the phase pins
`timescale 1ns/10ps
module quad_source (
   // Clock
   input wire logic clk_i,
   // Phase pins
   output logic phase_a_o,
   output logic phase_b_o
);
   logic [1:0] state;
   initial begin
      state = 2'h0;
   end
   assign phase_a_o = state[1];
   assign phase_b_o = state[0];
   task automatic step(input logic up);
      @(posedge clk_i);
      case (state)
         2'h0: state <= up ? 2'h2 : 2'h1;
         2'h2: state <= up ? 2'h3 : 2'h0;
         2'h3: state <= up ? 2'h1 : 2'h2;
         default: state <= up ? 2'h0 : 2'h3;
      endcase
      repeat (16) @(posedge clk_i);
   endtask
endmodule

// ==== verification/tb_top.sv ====
// Self-checking bench for the quadrature counter block
`timescale 1ns/10ps
module tb_top;
   logic clk_i = 1'b0;
   logic reset_i;
   logic [31:0] addr_i;
   logic [15:0] wdata_i;
   logic wr_i;
   logic rd_i;
   logic sleep_i;
   logic [15:0] rdata_o;
   logic [15:0] count_o;
   logic irq;
   logic wake_o;
   logic pa;
   logic pb;
   int error_cnt = 0;
   int checked = 0;
   logic [15:0] rv;
   always #25 clk_i = ~clk_i;
   qcnt_top u_qcnt_top (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .phase_a_input_i(pa), .phase_b_input_i(pb), .sleep_i(sleep_i),
      .updown_count_interrupt_o(irq), .wake_o(wake_o), .count_o(count_o));
   quad_source u_quad_source (.clk_i(clk_i), .phase_a_o(pa),
      .phase_b_o(pb));
   // ----------------------------------------
   // Bus and compare tasks
   // ----------------------------------------
   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      chk_word({15'h0, got}, {15'h0, exp});
   endtask
   task automatic wr_reg(input logic [31:0] a, input logic [15:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd_reg(input logic [31:0] a, output logic [15:0] d);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask
   task automatic wait_count(input logic [15:0] exp);
      int n;
      n = 0;
      while (count_o !== exp && n < 80) begin
         @(posedge clk_i);
         n++;
      end
      #1 chk_word(count_o, exp);
   endtask
   task automatic chk_status(input logic [15:0] exp);
      rd_reg(qcnt_pkg::OFS_STATUS, rv);
      chk_word(rv, exp);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      chk_status(16'h0000);
      rd_reg(32'hFFFF_F1F4, rv);
      chk_word(rv, 16'h0000);
      $display("test reset done");
   endtask
   task automatic t_mode();
      wr_reg(qcnt_pkg::OFS_RUN, 16'h0021);
      wr_reg(qcnt_pkg::OFS_RUN, 16'h0031);
      wait_count(16'h7FFF);
      wr_reg(qcnt_pkg::OFS_CAPTURE, 16'h0000);
      rd_reg(qcnt_pkg::OFS_COUNT, rv);
      chk_word(rv, 16'h7FFF);
      wr_reg(qcnt_pkg::OFS_MASK, 16'h001C);
      $display("test mode done");
   endtask
   task automatic t_step();
      u_quad_source.step(1'b1);
      wait_count(16'h8000);
      repeat (2) @(posedge clk_i);
      #1 chk_bit(irq, 1'b1);
      chk_status(16'h0010);
      chk_status(16'h0000);
      repeat (2) @(posedge clk_i);
      #1 chk_bit(irq, 1'b0);
      u_quad_source.step(1'b0);
      wait_count(16'h7FFF);
      chk_status(16'h0010);
      $display("test step done");
   endtask
   task automatic t_wrap();
      wr_reg(qcnt_pkg::OFS_COUNT, 16'hFFFF);
      wait_count(16'hFFFF);
      u_quad_source.step(1'b1);
      wait_count(16'h0000);
      chk_status(16'h0014);
      u_quad_source.step(1'b0);
      wait_count(16'hFFFF);
      chk_status(16'h0018);
      u_quad_source.step(1'b0);
      wait_count(16'hFFFE);
      chk_status(16'h0010);
      $display("test wrap done");
   endtask
   task automatic t_timer();
      wr_reg(qcnt_pkg::OFS_RUN, 16'h0021);
      u_quad_source.step(1'b0);
      repeat (40) @(posedge clk_i);
      #1 chk_word(count_o, 16'hFFFE);
      u_quad_source.step(1'b1);
      wait_count(16'hFFFF);
      rd_reg(qcnt_pkg::OFS_STATUS, rv);
      chk_word(rv, 16'h0010);
      $display("test timer done");
   endtask
   task automatic t_sleep();
      wr_reg(qcnt_pkg::OFS_RUN, 16'h0039);
      wait_count(16'h7FFF);
      @(posedge clk_i);
      sleep_i <= 1'b1;
      u_quad_source.step(1'b1);
      wait_count(16'h8000);
      repeat (2) @(posedge clk_i);
      #1 chk_bit(wake_o, 1'b1);
      chk_bit(irq, 1'b1);
      chk_status(16'h0010);
      repeat (2) @(posedge clk_i);
      #1 chk_bit(wake_o, 1'b0);
      @(posedge clk_i);
      sleep_i <= 1'b0;
      $display("test sleep done");
   endtask
   task automatic t_slow();
      wr_reg(qcnt_pkg::OFS_RUN, 16'h0011);
      u_quad_source.step(1'b0);
      repeat (640) @(posedge clk_i);
      #1 chk_word(count_o, 16'h7FFF);
      chk_status(16'h0010);
      $display("test slow done");
   endtask
   task automatic t_rerst();
      @(posedge clk_i);
      reset_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      reset_i <= 1'b0;
      #1 chk_word(count_o, 16'h0000);
      chk_bit(irq, 1'b0);
      chk_status(16'h0000);
      wr_reg(qcnt_pkg::OFS_RUN, 16'h0031);
      wait_count(16'h7FFF);
      u_quad_source.step(1'b1);
      wait_count(16'h8000);
      chk_status(16'h0010);
      $display("test rerun done");
   endtask
   // ----------------------------------------
   // Run control
   // ----------------------------------------
   task automatic complete_run();
      $display("checked=%0d error_cnt=%0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      reset_i <= 1'b1;
      addr_i <= 32'h0000_0000;
      wdata_i <= 16'h0000;
      wr_i <= 1'b0;
      rd_i <= 1'b0;
      sleep_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      reset_i <= 1'b0;
      t_reset();
      t_mode();
      t_step();
      t_wrap();
      t_timer();
      t_sleep();
      t_slow();
      t_rerst();
      complete_run();
   end
   initial begin
      #2000000;
      error_cnt++;
      complete_run();
   end
endmodule
